// File: rtl/fax_sig_pkg.sv
// Purpose: Shared constants and types for the fax session signalling block.
// Assumes: 32-bit AHB-Lite register bus, one 25 MHz clock.
// Notes: Control codes hold 0 in the leading X bit; matching masks that bit off.
package fax_sig_pkg;

  // Register byte addresses.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IMG = 8'h08;
  localparam logic [7:0] ADDR_CODE = 8'h0c;

  // Control register bit positions.
  localparam int CTRL_START = 0;
  localparam int CTRL_MORE = 1;
  localparam int CTRL_OPCALL = 2;
  localparam int CTRL_DISC = 3;
  localparam int CTRL_PAGE_END = 4;
  localparam int CTRL_RATE_LSB = 5;
  localparam int CTRL_RATE_MSB = 6;
  localparam int CTRL_LOCAL_INCH = 7;
  localparam int CTRL_PAGE_OK = 8;

  // Session control codes, leading X bit held at zero.
  localparam logic [7:0] CODE_CFR = 8'h21;
  localparam logic [7:0] CODE_FTT = 8'h22;
  localparam logic [7:0] CODE_MCF = 8'h31;
  localparam logic [7:0] CODE_PIP = 8'h35;
  localparam logic [7:0] CODE_DCN = 8'h5f;
  localparam logic [7:0] CODE_MPS = 8'h72;
  localparam logic [7:0] CODE_EOP = 8'h74;
  localparam logic [7:0] CODE_PRI_EOP = 8'h7c;
  localparam logic [7:0] CODE_MASK = 8'h7f;

  // Line words: 12 data bits plus a 4-bit count of valid bits.
  localparam logic [11:0] RTC_PATTERN = 12'h249;
  localparam logic [3:0] RTC_LEN = 4'hc;
  localparam logic [3:0] BYTE_LEN = 4'h8;
  localparam logic [7:0] TRAIN_WORD = 8'ha5;
  localparam logic [10:0] TRAIN_BYTES = 11'h010;
  localparam int TCF_TIME_MS = 1500;
  localparam int RATE_STEP_BPS = 2400;
  localparam logic [1:0] RATE_MIN = 2'h0;

  // Fifo shape.
  localparam int FIFO_WIDTH = 16;
  localparam int FIFO_DEPTH = 4;

  // One-hot session states.
  typedef enum logic [9:0] {
    ST_IDLE = 10'h001,
    ST_TRAIN = 10'h002,
    ST_TCF = 10'h004,
    ST_WAIT_ANS = 10'h008,
    ST_IMAGE = 10'h010,
    ST_RTC = 10'h020,
    ST_POST = 10'h040,
    ST_WAIT_MCF = 10'h080,
    ST_DCN = 10'h100,
    ST_RELEASE = 10'h200
  } sess_e;

  // Bytes of all-zero check sequence for a rate index (0 = 2400 bps).
  function automatic logic [10:0] tcf_bytes(input logic [1:0] rate);
    int bps;
    bps = RATE_STEP_BPS * (int'(rate) + 1);
    return 11'((bps * TCF_TIME_MS) / 8000);
  endfunction : tcf_bytes

  // Code match that ignores the leading X bit.
  function automatic logic code_is(input logic [7:0] code, input logic [7:0] ref_code);
    return (code & CODE_MASK) == (ref_code & CODE_MASK);
  endfunction : code_is

endpackage : fax_sig_pkg

// File: rtl/sess_fifo.sv
// Purpose: Small word fifo between the session framer and the modem port.
// Assumes: One clock; push and pop may happen in the same cycle.
// Notes: Output data come straight from the storage flops.
`timescale 1ns/10ps
module sess_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [CW-1:0] count;
  } fifo_s;

  fifo_s q;
  fifo_s next_q;
  logic push;
  logic pop;

  // Ready and valid come from the occupancy count only, never from the other side.
  assign in_ready = q.count != CW'(DEPTH);
  assign out_valid = q.count != '0;
  assign out_data = q.mem[q.rd];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Pointer and count update.
  always_comb begin
    next_q = q;
    if (push) begin
      next_q.mem[q.wr] = in_data;
      next_q.wr = (q.wr == PW'(DEPTH - 1)) ? '0 : PW'(q.wr + 1'b1);
    end
    if (pop) begin
      next_q.rd = (q.rd == PW'(DEPTH - 1)) ? '0 : PW'(q.rd + 1'b1);
    end
    if (push & ~pop) begin
      next_q.count = CW'(q.count + 1'b1);
    end else if (pop & ~push) begin
      next_q.count = CW'(q.count - 1'b1);
    end
  end

  // State register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
endmodule : sess_fifo

// File: rtl/fax_session_signal_control.sv
// Purpose: Session signalling for a group 3 fax terminal behind an AHB-Lite slave.
// Assumes: Modem-side framing and tcf checking run on hclk; all such inputs are synchronous.
// Notes: Line words leave through a 4-word fifo; the modem's ready stalls the framer.
// Contract
// - Bit 44 offers inch preference; in command frame selects 0 metric, 1 inch.
// - Bit 45 offers metric preference; command frame receiver ignores it.
// - Bit 46 offers half scan time at high resolution; ignored in command frame.
// - Sender transmits fixed training pattern at chosen rate, 2400 to 9600 bps.
// - After training, send all-zero check sequence for 1.5 seconds at same rate.
// - Check sequence received correctly: answer confirmation code X0100001.
// - Check sequence received badly: answer failure-to-train code X0100010.
// - On failure-to-train, sender lowers rate one step and trains again.
// - A second training precedes image data, done like the first one.
// - End of each sheet emits 12-bit marker, 001 four times, at image rate.
// - After the last page the sender transmits end-of-procedure code X1110100.
// - After a page is received well, receiver answers confirmation X0110001.
// - With more pages left, sender sends multi-page code X1110010 instead.
// - After multi-page code and confirmation, sender starts next sheet's image data.
// - On operator call, sender sends interrupt end code X1111100 after the marker.
// - On receiving operator call, receiver answers interrupt positive X0110101.
`timescale 1ns/10ps
module fax_session_signal_control (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic rx_code_valid,
  input wire logic [7:0] rx_code,
  input wire logic tcf_check_valid,
  input wire logic tcf_check_ok,
  input wire logic frame_valid,
  input wire logic frame_is_cmd,
  input wire logic [2:0] frame_bits,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [11:0] tx_data,
  output logic [3:0] tx_len,
  output logic [1:0] line_rate,
  output logic cmd_res_inch
);
  import fax_sig_pkg::*;

  typedef struct packed {
    sess_e st;
    logic [1:0] rate;
    logic [10:0] cnt;
    logic second;
    logic sent_mps;
    logic more;
    logic opcall;
    logic page_end;
    logic local_inch;
    logic page_ok;
    logic [1:0] start_rate;
    logic img_v;
    logic [7:0] img;
    logic resp_v;
    logic [7:0] resp;
    logic cmd_inch;
    logic rem_inch;
    logic rem_metric;
    logic rem_half;
    logic sel_inch;
    logic [7:0] last_code;
    logic dp_v;
    logic dp_wr;
    logic [7:0] dp_addr;
    logic [31:0] rdata;
  } sess_s;

  sess_s q;
  sess_s next_q;
  logic img_stall;
  logic wr_ctrl;
  logic wr_img;
  logic push_valid;
  logic [15:0] push_word;
  logic push_ready;
  logic fsm_fire;
  logic fsm_v;
  logic [15:0] fsm_w;
  logic rx_cfr;
  logic rx_ftt;
  logic rx_mcf;
  logic rx_pip;
  logic rx_mps;
  logic rx_eop;
  logic rx_pri;
  logic rx_dcn;
  logic released;
  logic [15:0] fifo_out;

  // An image write waits in its data phase while the previous byte is still held.
  assign img_stall = q.dp_v & q.dp_wr & (q.dp_addr == ADDR_IMG) & q.img_v;
  assign hreadyout = ~img_stall;
  assign hresp = 1'b0;
  assign hrdata = q.rdata;
  assign wr_ctrl = q.dp_v & q.dp_wr & ~img_stall & (q.dp_addr == ADDR_CTRL);
  assign wr_img = q.dp_v & q.dp_wr & ~img_stall & (q.dp_addr == ADDR_IMG);
  assign released = q.st == ST_RELEASE;

  // Received code decode with the X bit masked off.
  assign rx_cfr = rx_code_valid & code_is(rx_code, CODE_CFR);
  assign rx_ftt = rx_code_valid & code_is(rx_code, CODE_FTT);
  assign rx_mcf = rx_code_valid & code_is(rx_code, CODE_MCF);
  assign rx_pip = rx_code_valid & code_is(rx_code, CODE_PIP);
  assign rx_mps = rx_code_valid & code_is(rx_code, CODE_MPS);
  assign rx_eop = rx_code_valid & code_is(rx_code, CODE_EOP);
  assign rx_pri = rx_code_valid & code_is(rx_code, CODE_PRI_EOP);
  assign rx_dcn = rx_code_valid & code_is(rx_code, CODE_DCN);

  // Pending receiver answers go ahead of the sender's stream.
  assign push_valid = q.resp_v | fsm_v;
  assign push_word = q.resp_v ? {BYTE_LEN, 4'h0, q.resp} : fsm_w;
  assign fsm_fire = push_ready & ~q.resp_v; // Fifo ready and no pending answer, so the framer's valid never loops into its decode.
  assign tx_len = fifo_out[15:12];
  assign tx_data = fifo_out[11:0];
  assign line_rate = q.rate;
  assign cmd_res_inch = q.sel_inch;

  // Next-state logic for bus, capability, answers and the sender sequence.
  always_comb begin
    next_q = q;
    fsm_v = 1'b0;
    fsm_w = '0;

    // Address phase capture; read data are sampled here so they come from a flop.
    if (hsel & htrans[1] & hready) begin
      next_q.dp_v = 1'b1;
      next_q.dp_wr = hwrite;
      next_q.dp_addr = haddr[7:0];
      case (haddr[7:0])
        ADDR_CTRL: next_q.rdata = {23'h0, q.page_ok, q.local_inch, q.start_rate, 2'h0, q.opcall, q.more, 1'b0};
        ADDR_STATUS: next_q.rdata = {13'h0, q.img_v, released, q.sel_inch, q.rem_half, q.rem_metric,
                                     q.rem_inch, q.cmd_inch, q.rate, q.st};
        ADDR_CODE: next_q.rdata = {24'h0, q.last_code};
        default: next_q.rdata = '0;
      endcase
    end else if (hreadyout) begin
      next_q.dp_v = 1'b0;
    end

    // Control write: level bits stored, pulse bits acted on below.
    if (wr_ctrl) begin
      next_q.more = hwdata[CTRL_MORE];
      next_q.opcall = hwdata[CTRL_OPCALL];
      next_q.start_rate = hwdata[CTRL_RATE_MSB:CTRL_RATE_LSB];
      next_q.local_inch = hwdata[CTRL_LOCAL_INCH];
      next_q.page_ok = hwdata[CTRL_PAGE_OK];
      if (hwdata[CTRL_PAGE_END]) begin
        next_q.page_end = 1'b1;
      end
    end
    if (wr_img) begin
      next_q.img_v = 1'b1;
      next_q.img = hwdata[7:0];
    end

    // Capability bits: offer frames record all three, command frames only the type.
    if (frame_valid) begin
      if (frame_is_cmd) begin
        next_q.cmd_inch = frame_bits[0];
      end else begin
        next_q.rem_inch = frame_bits[0];
        next_q.rem_metric = frame_bits[1];
        next_q.rem_half = frame_bits[2];
      end
    end
    // Choose inch only when offered and not overruled by a metric preference.
    next_q.sel_inch = next_q.rem_inch & (next_q.local_inch | ~next_q.rem_metric);
    if (rx_code_valid) begin
      next_q.last_code = rx_code;
    end

    // Receiver answers; a new answer overwrites one that leaves this cycle.
    if (q.resp_v & push_ready) begin
      next_q.resp_v = 1'b0;
    end
    if (!released) begin
      if (tcf_check_valid) begin
        next_q.resp_v = 1'b1;
        next_q.resp = tcf_check_ok ? CODE_CFR : CODE_FTT;
      end else if (rx_pri) begin
        next_q.resp_v = 1'b1;
        next_q.resp = CODE_PIP;
      end else if ((rx_mps | rx_eop) & q.page_ok) begin
        next_q.resp_v = 1'b1;
        next_q.resp = CODE_MCF;
      end
    end

    // Sender sequence.
    case (q.st)
      ST_IDLE, ST_RELEASE: begin
        if (wr_ctrl & hwdata[CTRL_START]) begin
          next_q.st = ST_TRAIN;
          next_q.rate = next_q.start_rate;
          next_q.second = 1'b0;
          next_q.cnt = '0;
        end
      end
      ST_TRAIN: begin
        fsm_v = 1'b1;
        fsm_w = {BYTE_LEN, 4'h0, TRAIN_WORD};
        if (fsm_fire) begin
          if (q.cnt == TRAIN_BYTES - 11'h001) begin
            next_q.cnt = '0;
            next_q.st = q.second ? ST_IMAGE : ST_TCF;
          end else begin
            next_q.cnt = q.cnt + 11'h001;
          end
        end
      end
      ST_TCF: begin
        fsm_v = 1'b1;
        fsm_w = {BYTE_LEN, 12'h000};
        if (fsm_fire) begin
          if (q.cnt == tcf_bytes(q.rate) - 11'h001) begin
            next_q.cnt = '0;
            next_q.st = ST_WAIT_ANS;
          end else begin
            next_q.cnt = q.cnt + 11'h001;
          end
        end
      end
      ST_WAIT_ANS: begin
        if (rx_cfr) begin
          next_q.st = ST_TRAIN;
          next_q.second = 1'b1;
        end else if (rx_ftt) begin
          // At the lowest rate there is no step left, so training repeats there.
          next_q.st = ST_TRAIN;
          next_q.second = 1'b0;
          if (q.rate != RATE_MIN) begin
            next_q.rate = q.rate - 2'h1;
          end
        end
      end
      ST_IMAGE: begin
        if (q.img_v) begin
          fsm_v = 1'b1;
          fsm_w = {BYTE_LEN, 4'h0, q.img};
          if (fsm_fire) begin
            next_q.img_v = 1'b0;
          end
        end else if (q.page_end & ~wr_img) begin
          next_q.page_end = wr_ctrl & hwdata[CTRL_PAGE_END]; // A page end written now is kept for the next sheet.
          next_q.st = ST_RTC;
        end
      end
      ST_RTC: begin
        fsm_v = 1'b1;
        fsm_w = {RTC_LEN, RTC_PATTERN};
        if (fsm_fire) begin
          next_q.st = ST_POST;
        end
      end
      ST_POST: begin
        fsm_v = 1'b1;
        if (q.opcall) begin
          fsm_w = {BYTE_LEN, 4'h0, CODE_PRI_EOP};
        end else if (q.more) begin
          fsm_w = {BYTE_LEN, 4'h0, CODE_MPS};
        end else begin
          fsm_w = {BYTE_LEN, 4'h0, CODE_EOP};
        end
        if (fsm_fire) begin
          next_q.sent_mps = q.more & ~q.opcall;
          next_q.st = ST_WAIT_MCF;
        end
      end
      ST_WAIT_MCF: begin
        if (rx_mcf | rx_pip) begin
          next_q.st = q.sent_mps ? ST_IMAGE : ST_DCN;
        end
      end
      ST_DCN: begin
        fsm_v = 1'b1;
        fsm_w = {BYTE_LEN, 4'h0, CODE_DCN};
        if (fsm_fire) begin
          next_q.st = ST_RELEASE;
        end
      end
      default: begin
        next_q.st = ST_IDLE;
      end
    endcase

    // Disconnect: a received one ends everything at once, a requested one is sent first.
    if (rx_dcn & (q.st != ST_IDLE)) begin
      next_q.st = ST_RELEASE;
      next_q.resp_v = 1'b0;
    end else if (wr_ctrl & hwdata[CTRL_DISC] & (q.st != ST_IDLE) & ~released) begin
      next_q.st = ST_DCN;
    end
  end

  // State register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.st <= ST_IDLE;
    end else begin
      q <= next_q;
    end
  end

  // Outgoing line words; the modem's ready back-pressures the framer through it.
  sess_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .hclk(hclk),
    .hresetn(hresetn),
    .in_valid(push_valid),
    .in_data(push_word),
    .in_ready(push_ready),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(fifo_out)
  );

  // Checks on the session sequence.
  a_ftt_rate_down: assert property (@(posedge hclk) disable iff (!hresetn)
    (q.st == ST_WAIT_ANS) && rx_ftt && !rx_dcn && !wr_ctrl && (q.rate != RATE_MIN) |=>
      (q.rate == $past(q.rate) - 2'h1) && (q.st == ST_TRAIN) && !q.second)
    else $error("rate not lowered by one step after failure to train");
  a_cfr_second_train: assert property (@(posedge hclk) disable iff (!hresetn)
    (q.st == ST_WAIT_ANS) && rx_cfr && !rx_dcn && !wr_ctrl |=> (q.st == ST_TRAIN) && q.second && (q.cnt == '0))
    else $error("confirmation did not start the second training");
  a_tcf_all_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (q.st == ST_TCF) && !q.resp_v |-> push_valid && (push_word == {BYTE_LEN, 12'h000}))
    else $error("check sequence word is not all zero");
  a_rtc_marker: assert property (@(posedge hclk) disable iff (!hresetn)
    (q.st == ST_IMAGE) && !q.img_v && q.page_end && !rx_dcn && !wr_ctrl && !wr_img ##1 !q.resp_v |->
      (push_word == {RTC_LEN, RTC_PATTERN}))
    else $error("end of sheet marker missing or wrong");
  a_post_code: assert property (@(posedge hclk) disable iff (!hresetn)
    (q.st == ST_POST) && !q.resp_v |-> push_word[7:0] ==
      (q.opcall ? CODE_PRI_EOP : (q.more ? CODE_MPS : CODE_EOP)))
    else $error("wrong post-message code");
  a_next_sheet: assert property (@(posedge hclk) disable iff (!hresetn)
    (q.st == ST_WAIT_MCF) && rx_mcf && q.sent_mps && !rx_dcn && !wr_ctrl |=> (q.st == ST_IMAGE))
    else $error("next sheet not started after confirmation");
  a_tcf_answer: assert property (@(posedge hclk) disable iff (!hresetn)
    tcf_check_valid && !released && !rx_dcn |=>
      q.resp_v && (q.resp == ($past(tcf_check_ok) ? CODE_CFR : CODE_FTT)))
    else $error("wrong answer to training check");
  a_dcn_release: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_dcn && (q.st != ST_IDLE) |=> released && !q.resp_v ##1 (released || $past(wr_ctrl)))
    else $error("disconnect did not enter release");
  a_cmd_type: assert property (@(posedge hclk) disable iff (!hresetn)
    frame_valid && frame_is_cmd |=> (q.cmd_inch == $past(frame_bits[0])) &&
      (q.rem_metric == $past(q.rem_metric)) && (q.rem_half == $past(q.rem_half)))
    else $error("command frame capability handled wrongly");
  a_pip_answer: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_pri && !tcf_check_valid && !released |=> q.resp_v && (q.resp == CODE_PIP))
    else $error("operator call not answered");
endmodule : fax_session_signal_control

// File: verif/remote_fax_model.sv
// Purpose: Remote fax terminal on the modem side of the session block.
// Assumes: Codes and check results arrive as one-cycle pulses on hclk.
// Notes: Idle code lines carry changing noise, so a stale value is never mistaken for a code.
`timescale 1ns/10ps
module remote_fax_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [1:0] pace,
  input wire logic tx_valid,
  input wire logic [11:0] tx_data,
  input wire logic [3:0] tx_len,
  output logic tx_ready,
  output logic rx_code_valid,
  output logic [7:0] rx_code,
  output logic tcf_check_valid,
  output logic tcf_check_ok
);
  logic [15:0] words[$];
  logic [7:0] code_q = 8'h00;
  logic [7:0] noise = 8'h5a;
  logic ok_q = 1'b0;
  logic code_go = 1'b0;
  logic tcf_go = 1'b0;
  logic tog;

  // Words are logged in line order; pace 1 takes every other cycle and pace 2 stalls the line.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_ready <= 1'b0;
      tog <= 1'b0;
    end else begin
      tog <= ~tog;
      noise <= ~noise;
      tx_ready <= (pace == 2'h0) || (pace == 2'h1 && tog);
      if (tx_valid && tx_ready) words.push_back({tx_len, tx_data});
    end
  end

  // Qualifiers are valid only in their pulse cycle.
  assign rx_code_valid = code_go;
  assign rx_code = code_go ? code_q : noise;
  assign tcf_check_valid = tcf_go;
  assign tcf_check_ok = tcf_go ? ok_q : noise[0];

  // Delivers one received control code for a single cycle.
  task automatic send_code(input logic [7:0] c);
    @(posedge hclk);
    code_q <= c;
    code_go <= 1'b1;
    @(posedge hclk);
    code_go <= 1'b0;
  endtask : send_code

  // Reports whether the all-zero check sequence came through intact.
  task automatic send_tcf(input logic ok);
    @(posedge hclk);
    ok_q <= ok;
    tcf_go <= 1'b1;
    @(posedge hclk);
    tcf_go <= 1'b0;
  endtask : send_tcf
endmodule : remote_fax_model

// File: verif/test_fax_session_signal_control.sv
// Purpose: Self-checking bench for the fax session signalling block.
// Assumes: One AHB-Lite master, hready tied to hreadyout, remote model on the line side.
// Notes: Expected words come from package codes and the 1.5 s check length.
`timescale 1ns/10ps
module test_fax_session_signal_control;
  import fax_sig_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, rx_code_valid, tcf_check_valid, tcf_check_ok, tx_valid, tx_ready, cmd_res_inch, hresp;
  logic [31:0] hrdata;
  logic [31:0] dummy;
  logic [7:0] rx_code;
  logic frame_valid = 1'b0;
  logic frame_is_cmd = 1'b0;
  logic [2:0] frame_bits = 3'h0;
  logic [11:0] tx_data;
  logic [3:0] tx_len;
  logic [1:0] line_rate;
  logic [1:0] pace = 2'h0;
  int n_mismatch = 0;
  int tests_run = 0;

  // A 40 ns clock for the 25 MHz bus.
  always #20 hclk = ~hclk;

  fax_session_signal_control DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .rx_code_valid(rx_code_valid), .rx_code(rx_code), .tcf_check_valid(tcf_check_valid),
    .tcf_check_ok(tcf_check_ok), .frame_valid(frame_valid), .frame_is_cmd(frame_is_cmd),
    .frame_bits(frame_bits), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .tx_len(tx_len), .line_rate(line_rate), .cmd_res_inch(cmd_res_inch)
  );

  remote_fax_model peer (
    .hclk(hclk), .hresetn(hresetn), .pace(pace), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_len(tx_len), .tx_ready(tx_ready), .rx_code_valid(rx_code_valid), .rx_code(rx_code),
    .tcf_check_valid(tcf_check_valid), .tcf_check_ok(tcf_check_ok)
  );

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  // Waits for hready at a rising edge; a stuck slave is left to the watchdog.
  task automatic wait_rdy();
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      @(posedge hclk);
    end
  endtask : wait_rdy

  // One single AHB-Lite word transfer: address phase, then data phase.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, dummy);
  endtask : wr

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(what, e, r & m);
  endtask : rd_chk

  // Takes n line words from the model and compares each one.
  task automatic run(input logic [3:0] l, input logic [11:0] d, input int n);
    int k;
    repeat (n) begin
      k = 0;
      while (peer.words.size() == 0 && k < 300) begin
        @(posedge hclk);
        k++;
      end
      chk("line word", {16'h0, l, d}, {16'h0, peer.words.size() ? peer.words.pop_front() : 16'hxxxx});
    end
  endtask : run

  // Check sequence length in bytes for a rate index.
  function automatic int tcf(input int r);
    return RATE_STEP_BPS * (r + 1) * TCF_TIME_MS / 8000;
  endfunction : tcf

  task automatic frame(input logic c, input logic [2:0] b);
    @(posedge hclk);
    frame_valid <= 1'b1;
    frame_is_cmd <= c;
    frame_bits <= b;
    @(posedge hclk);
    frame_valid <= 1'b0;
    frame_bits <= ~b;
  endtask : frame

  task automatic t_reset();
    rd_chk("status", ADDR_STATUS, 32'hffffffff, 32'h1);
    wr(8'h10, 32'hffffffff);
    rd_chk("unmapped", 8'h10, 32'hffffffff, 32'h0);
    chk("rate", 32'h0, {30'h0, line_rate});
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : t_reset

  // Offer bits are kept, command bits 45 and 46 are not.
  task automatic t_caps();
    frame(1'b0, 3'h5);
    rd_chk("caps", ADDR_STATUS, 32'h1f000, 32'h1a000);
    chk("inch", 32'h1, {31'h0, cmd_res_inch});
    frame(1'b0, 3'h3);
    rd_chk("caps", ADDR_STATUS, 32'h1f000, 32'h06000);
    wr(ADDR_CTRL, 32'h80);
    frame(1'b0, 3'h3);
    rd_chk("caps", ADDR_STATUS, 32'h1f000, 32'h16000);
    frame(1'b1, 3'h7);
    rd_chk("caps", ADDR_STATUS, 32'h1f000, 32'h17000);
    frame(1'b1, 3'h0);
    rd_chk("caps", ADDR_STATUS, 32'h1f000, 32'h16000);
    wr(ADDR_CTRL, 32'h0);
  endtask : t_caps

  // Receiver answers, with the leading bit set on some codes.
  task automatic t_answers();
    wr(ADDR_CTRL, 32'h100);
    peer.send_tcf(1'b1);
    run(BYTE_LEN, {4'h0, CODE_CFR}, 1);
    peer.send_tcf(1'b0);
    run(BYTE_LEN, {4'h0, CODE_FTT}, 1);
    peer.send_code(CODE_PRI_EOP | 8'h80);
    run(BYTE_LEN, {4'h0, CODE_PIP}, 1);
    peer.send_code(CODE_MPS);
    run(BYTE_LEN, {4'h0, CODE_MCF}, 1);
    peer.send_code(CODE_EOP | 8'h80);
    run(BYTE_LEN, {4'h0, CODE_MCF}, 1);
    rd_chk("code", ADDR_CODE, 32'hff, 32'hf4);
    wr(ADDR_CTRL, 32'h0);
  endtask : t_answers

  // Fallback from 9600, two pages through a stalled fifo, then operator call.
  task automatic t_session();
    wr(ADDR_CTRL, 32'h63);
    run(BYTE_LEN, {4'h0, TRAIN_WORD}, TRAIN_BYTES);
    run(BYTE_LEN, 12'h0, tcf(3));
    rd_chk("status", ADDR_STATUS, 32'hfff, 32'hc08);
    peer.send_code(CODE_FTT | 8'h80);
    run(BYTE_LEN, {4'h0, TRAIN_WORD}, TRAIN_BYTES);
    run(BYTE_LEN, 12'h0, tcf(2));
    chk("rate", 32'h2, {30'h0, line_rate});
    peer.send_code(CODE_CFR);
    run(BYTE_LEN, {4'h0, TRAIN_WORD}, TRAIN_BYTES);
    rd_chk("status", ADDR_STATUS, 32'hfff, 32'h810);
    pace <= 2'h2;
    for (int i = 1; i <= 5; i++) wr(ADDR_IMG, 32'h11 * i);
    rd_chk("held", ADDR_STATUS, 32'h40000, 32'h40000);
    pace <= 2'h1;
    wr(ADDR_CTRL, 32'h12);
    for (int i = 1; i <= 5; i++) run(BYTE_LEN, 12'(i * 17), 1);
    run(RTC_LEN, RTC_PATTERN, 1);
    run(BYTE_LEN, {4'h0, CODE_MPS}, 1);
    rd_chk("status", ADDR_STATUS, 32'hfff, 32'h880);
    chk("empty", 32'h0, {31'h0, tx_valid});
    peer.send_code(CODE_MCF);
    rd_chk("status", ADDR_STATUS, 32'hfff, 32'h810);
    wr(ADDR_IMG, 32'h66);
    wr(ADDR_CTRL, 32'h14);
    run(BYTE_LEN, 12'h66, 1);
    run(RTC_LEN, RTC_PATTERN, 1);
    run(BYTE_LEN, {4'h0, CODE_PRI_EOP}, 1);
    peer.send_code(CODE_PIP);
    run(BYTE_LEN, {4'h0, CODE_DCN}, 1);
    rd_chk("status", ADDR_STATUS, 32'h3ff, 32'h200);
    pace <= 2'h0;
  endtask : t_session

  // Last page at 2400 ends with the end code; a received disconnect silences the line.
  task automatic t_end();
    wr(ADDR_CTRL, 32'h1);
    run(BYTE_LEN, {4'h0, TRAIN_WORD}, TRAIN_BYTES);
    run(BYTE_LEN, 12'h0, tcf(0));
    peer.send_code(CODE_CFR);
    run(BYTE_LEN, {4'h0, TRAIN_WORD}, TRAIN_BYTES);
    wr(ADDR_CTRL, 32'h10);
    run(RTC_LEN, RTC_PATTERN, 1);
    run(BYTE_LEN, {4'h0, CODE_EOP}, 1);
    peer.send_code(CODE_DCN | 8'h80);
    peer.send_tcf(1'b1);
    repeat (20) @(posedge hclk);
    chk("silent", 32'h0, peer.words.size());
    rd_chk("status", ADDR_STATUS, 32'h3ff, 32'h200);
    // A disconnect request during training leaves three training words, then the disconnect code.
    wr(ADDR_CTRL, 32'h1);
    wr(ADDR_CTRL, 32'h8);
    run(BYTE_LEN, {4'h0, TRAIN_WORD}, 3);
    run(BYTE_LEN, {4'h0, CODE_DCN}, 1);
    rd_chk("status", ADDR_STATUS, 32'h3ff, 32'h200);
  endtask : t_end

  // Reset for six cycles, then the scenarios in order.
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_caps();
    t_answers();
    t_session();
    t_end();
    wrap_up();
  end

  // Cuts a hang short well beyond the expected run length.
  initial begin
    #(40 * 40000);
    n_mismatch++;
    wrap_up();
  end
endmodule : test_fax_session_signal_control
